// >>> src/dotv_pkg.sv
// Package with register layout, field positions and carrier types for the termination selector
package dotv_pkg;
    localparam logic [7:0] VEC_REG_OFFSET = 8'hB0;
    localparam logic [31:0] VEC_REG_RESET = 32'h0000_0000;
    localparam logic [15:0] REMAP_IDENTITY = 16'h8421;
    localparam logic [15:0] REMAP_RESET = 16'h8421;
    localparam int RANK_BYTE_W = 8;
    localparam int READ_NIB_LSB = 0;
    localparam int WRITE_NIB_LSB = 4;
    localparam int NIB_W = 4;

    typedef struct packed {
        logic valid;
        logic is_write;
        logic [1:0] rank;
    } dotv_access_type;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } dotv_cfg_req_type;
endpackage

// >>> src/dotv_vec_store.sv
// Register holding the four per-rank termination vectors
`timescale 1ns/100ps
module dotv_vec_store
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic wr_i,
    input wire logic [31:0] wdata_i,
    output logic [31:0] vec_o
);
    logic [31:0] vec_ff;
    logic [31:0] nxt_vec;

    always_comb
    begin
        nxt_vec = vec_ff;
        if (wr_i)
        begin
            nxt_vec = wdata_i;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            vec_ff <= dotv_pkg::VEC_REG_RESET;
        end
        else
        begin
            vec_ff <= nxt_vec;
        end
    end

    assign vec_o = vec_ff;
endmodule // dotv_vec_store

// >>> src/dotv_top.sv
// Termination vector selector driving the odd chip-select lines of both channels
`timescale 1ns/100ps
module dotv_top
(
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    input wire dotv_pkg::dotv_cfg_req_type CFG_REQ_I,
    input wire dotv_pkg::dotv_access_type ACCESS_I,
    input wire logic DUAL_CHANNEL_I,
    input wire logic DDR2_MODE_I,
    input wire logic [15:0] CHIP_SELECT_REMAP_I,
    output logic [31:0] CFG_RDATA_O,
    output logic [3:0] CH0_TERM_O,
    output logic [3:0] CH1_TERM_O
);
    // Register bus side
    logic cfg_hit;
    logic cfg_wr;
    logic cfg_rd;
    logic [31:0] vec;
    logic [31:0] rdata_ff;
    logic [31:0] nxt_rdata;

    // Per-rank fields of the stored vector
    logic [3:0] rank0_read_term;
    logic [3:0] rank0_write_term;
    logic [3:0] rank2_read_term;
    logic [3:0] rank2_write_term;
    logic [3:0] rank4_read_term;
    logic [3:0] rank4_write_term;
    logic [3:0] rank6_read_term;
    logic [3:0] rank6_write_term;

    // Selection and the two channel outputs
    logic term_on;
    logic remap_direct;
    logic [3:0] nib;
    logic [3:0] phys;
    logic [3:0] ch0_ff;
    logic [3:0] nxt_ch0;
    logic [3:0] ch1_ff;
    logic [3:0] nxt_ch1;

    // Byte of a rank starts at eight times its index, write nibble above the read one
    function automatic logic [3:0] rank_nibble
    (
        input logic [31:0] v,
        input logic [1:0] rank,
        input logic is_write
    );
        int lsb;
        lsb = int'(rank) * dotv_pkg::RANK_BYTE_W;
        if (is_write)
        begin
            lsb = lsb + dotv_pkg::WRITE_NIB_LSB;
        end
        else
        begin
            lsb = lsb + dotv_pkg::READ_NIB_LSB;
        end
        return v[lsb +: dotv_pkg::NIB_W];
    endfunction

    // Nibble i of the remap word is the one-hot target of nibble bit i; targets
    // are ORed, so a malformed map may widen termination, and an all-zero target drops its set bit
    function automatic logic [3:0] remap_lines
    (
        input logic [3:0] n,
        input logic [15:0] map
    );
        logic [3:0] r;
        r = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            if (n[i])
            begin
                r = r | map[i*4 +: 4];
            end
        end
        return r;
    endfunction

    // Only the one offset is decoded; writes elsewhere are dropped
    assign cfg_hit = CFG_REQ_I.addr == dotv_pkg::VEC_REG_OFFSET;
    assign cfg_wr = CFG_REQ_I.wr && cfg_hit;
    assign cfg_rd = CFG_REQ_I.rd && cfg_hit;

    dotv_vec_store dotv_vec_store_i
    (
        .clk_i(SYS_CLK_I),
        .rstn_i(RSTN_I),
        .wr_i(cfg_wr),
        .wdata_i(CFG_REQ_I.wdata),
        .vec_o(vec)
    );

    // Read word stands one cycle and is zero otherwise, so no stale data lingers
    always_comb
    begin
        nxt_rdata = 32'h0000_0000;
        if (cfg_rd)
        begin
            nxt_rdata = vec;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            rdata_ff <= 32'h0000_0000;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
        end
    end

    assign rank0_read_term = rank_nibble(vec, 2'd0, 1'b0);
    assign rank0_write_term = rank_nibble(vec, 2'd0, 1'b1);
    assign rank2_read_term = rank_nibble(vec, 2'd1, 1'b0);
    assign rank2_write_term = rank_nibble(vec, 2'd1, 1'b1);
    assign rank4_read_term = rank_nibble(vec, 2'd2, 1'b0);
    assign rank4_write_term = rank_nibble(vec, 2'd2, 1'b1);
    assign rank6_read_term = rank_nibble(vec, 2'd3, 1'b0);
    assign rank6_write_term = rank_nibble(vec, 2'd3, 1'b1);

    // Termination only while an access is presented in DDR2 mode
    assign term_on = ACCESS_I.valid && DDR2_MODE_I;
    assign remap_direct = CHIP_SELECT_REMAP_I == dotv_pkg::REMAP_IDENTITY;

    // Rank index 0..3 stands for logical chip selects 0, 2, 4 and 6
    always_comb
    begin
        case ({ACCESS_I.is_write, ACCESS_I.rank})
            3'b000:
            begin
                nib = rank0_read_term;
            end
            3'b001:
            begin
                nib = rank2_read_term;
            end
            3'b010:
            begin
                nib = rank4_read_term;
            end
            3'b011:
            begin
                nib = rank6_read_term;
            end
            3'b100:
            begin
                nib = rank0_write_term;
            end
            3'b101:
            begin
                nib = rank2_write_term;
            end
            3'b110:
            begin
                nib = rank4_write_term;
            end
            3'b111:
            begin
                nib = rank6_write_term;
            end
            default:
            begin
                nib = 4'h0;
            end
        endcase
    end

    // Bits 3..0 stand for odd lines 7, 5, 3 and 1; remap is applied before the flops
    always_comb
    begin
        if (remap_direct)
        begin
            phys = nib;
        end
        else
        begin
            phys = remap_lines(nib, CHIP_SELECT_REMAP_I);
        end
    end

    // Channel 0 follows the access cycle by cycle, one clock late
    always_comb
    begin
        nxt_ch0 = 4'h0;
        if (term_on)
        begin
            nxt_ch0 = phys;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            ch0_ff <= 4'h0;
        end
        else
        begin
            ch0_ff <= nxt_ch0;
        end
    end

    // Channel 1 held off in single-channel mode so an unused channel stays quiet
    always_comb
    begin
        nxt_ch1 = 4'h0;
        if (term_on && DUAL_CHANNEL_I)
        begin
            nxt_ch1 = phys;
        end
    end

    always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
    begin
        if (!RSTN_I)
        begin
            ch1_ff <= 4'h0;
        end
        else
        begin
            ch1_ff <= nxt_ch1;
        end
    end

    assign CFG_RDATA_O = rdata_ff;
    assign CH0_TERM_O = ch0_ff;
    assign CH1_TERM_O = ch1_ff;
endmodule // dotv_top

// >>> tb/dotv_rank_model.sv
// Far-side rank model that records which termination lines it has seen
`timescale 1ns/100ps
module dotv_rank_model
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic [3:0] term_i,
    output logic [3:0] seen_o
);
    // Lines the rank has seen asserted since the last reset
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            seen_o <= 4'h0;
        else
            seen_o <= seen_o | term_i;
    end
endmodule // dotv_rank_model

// >>> tb/dotv_chk_sva.sv
// Checker for the termination selector
`timescale 1ns/100ps
module dotv_chk
(
    input wire logic SYS_CLK_I,
    input wire logic RSTN_I,
    input wire dotv_pkg::dotv_cfg_req_type CFG_REQ_I,
    input wire dotv_pkg::dotv_access_type ACCESS_I,
    input wire logic DUAL_CHANNEL_I,
    input wire logic DDR2_MODE_I,
    input wire logic [15:0] CHIP_SELECT_REMAP_I,
    input wire logic [31:0] CFG_RDATA_O,
    input wire logic [3:0] CH0_TERM_O,
    input wire logic [3:0] CH1_TERM_O
);
    default clocking @(posedge SYS_CLK_I); endclocking
    default disable iff (!RSTN_I);
    logic [31:0] v_ff;
    wire hit = CFG_REQ_I.addr == dotv_pkg::VEC_REG_OFFSET;
    wire on = ACCESS_I.valid && DDR2_MODE_I;
    wire [3:0] n = v_ff[{ACCESS_I.rank, ACCESS_I.is_write, 2'b00} +: 4];
    wire [15:0] r = CHIP_SELECT_REMAP_I;
    // Each nibble bit spreads through its own one-hot remap mask
    wire [3:0] m = {4{n[0]}} & r[3:0] | {4{n[1]}} & r[7:4] | {4{n[2]}} & r[11:8]
        | {4{n[3]}} & r[15:12];
    always_ff @(posedge SYS_CLK_I or negedge RSTN_I)
        if (!RSTN_I)
            v_ff <= '0;
        else if (CFG_REQ_I.wr && hit)
            v_ff <= CFG_REQ_I.wdata;
    term_sel_a: assert property (on |=> CH0_TERM_O == $past(m)) else $error("sel");
    dual_same_a: assert property (DUAL_CHANNEL_I |=> CH1_TERM_O == CH0_TERM_O) else $error("dual");
    single_off_a: assert property (!DUAL_CHANNEL_I |=> CH1_TERM_O == 4'h0) else $error("ch1");
    mode_off_a: assert property (!DDR2_MODE_I |=> CH0_TERM_O == 4'h0) else $error("mode");
    idle_off_a: assert property (!ACCESS_I.valid |=> CH0_TERM_O == 4'h0) else $error("idle");
    vec_read_a: assert property (CFG_REQ_I.rd && hit |=> CFG_RDATA_O == $past(v_ff)) else $error("rd");
    rdata_zero_a: assert property (!(CFG_REQ_I.rd && hit) |=> CFG_RDATA_O == '0) else $error("rz");
    reset_zero_a: assert property ($rose(RSTN_I) |-> CH0_TERM_O == 4'h0 && CFG_RDATA_O == '0) else $error("rst");
    cover property (on && DUAL_CHANNEL_I && ACCESS_I.is_write);
    cover property (CFG_REQ_I.wr ##1 CFG_REQ_I.rd);
    cover property (on && r != dotv_pkg::REMAP_IDENTITY);
endmodule // dotv_chk
bind dotv_top dotv_chk dotv_chk_i
(
    .SYS_CLK_I(SYS_CLK_I),
    .RSTN_I(RSTN_I),
    .CFG_REQ_I(CFG_REQ_I),
    .ACCESS_I(ACCESS_I),
    .DUAL_CHANNEL_I(DUAL_CHANNEL_I),
    .DDR2_MODE_I(DDR2_MODE_I),
    .CHIP_SELECT_REMAP_I(CHIP_SELECT_REMAP_I),
    .CFG_RDATA_O(CFG_RDATA_O),
    .CH0_TERM_O(CH0_TERM_O),
    .CH1_TERM_O(CH1_TERM_O)
);

// >>> tb/tb_top.sv
// Self-checking bench for the termination selector
`timescale 1ns/100ps
module tb_top;
    logic clk = 0, rstn = 0, dual = 0, ddr2 = 1;
    dotv_pkg::dotv_cfg_req_type req = '0;
    dotv_pkg::dotv_access_type acc = '0;
    logic [15:0] remap = 16'h8421;
    logic [31:0] rdata;
    logic [3:0] ch0, ch1;
    logic [3:0] seen1;
    int err_total = 0, samples_checked = 0;
    // Row: {is_write, rank, expected nibble} for vector 9ABC_DE5F
    logic [6:0] rows [8] = '{7'h0F, 7'h45, 7'h1E, 7'h5D, 7'h2C, 7'h6B, 7'h3A, 7'h79};
    always #5 clk = ~clk;
    dotv_top dotv_top_i (.SYS_CLK_I(clk), .RSTN_I(rstn), .CFG_REQ_I(req), .ACCESS_I(acc),
        .DUAL_CHANNEL_I(dual), .DDR2_MODE_I(ddr2), .CHIP_SELECT_REMAP_I(remap),
        .CFG_RDATA_O(rdata), .CH0_TERM_O(ch0), .CH1_TERM_O(ch1));
    dotv_rank_model dotv_rank_model_i (.clk_i(clk), .rstn_i(rstn), .term_i(ch1),
        .seen_o(seen1));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task cfg(input logic r, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk) req <= '{!r, r, a, d};
        @(posedge clk) req <= '0;
        #1;
    endtask
    task acs(input logic [2:0] wr_rank, input logic d, input logic [3:0] exp);
        @(posedge clk) {acc, dual} <= {1'b1, wr_rank, d};
        @(posedge clk) #1 chk(ch0, exp);
        chk(ch1, d ? exp : 4'h0);
    endtask
    initial
    begin
        repeat (3) @(posedge clk);
        rstn <= 1;
        #1 chk(rdata, '0);
        chk(ch0, '0);
        cfg(0, 8'hB0, 32'h9ABC_DE5F);
        for (int i = 0; i < 8; i++)
            acs(rows[i][6:4], i[0], rows[i][3:0]);
        chk(seen1, 4'hF);
        cfg(0, 8'hB4, 32'hFFFF_FFFF);
        cfg(1, 8'hB0, '0);
        chk(rdata, 32'h9ABC_DE5F);
        cfg(1, 8'hB4, '0);
        chk(rdata, '0);
        @(posedge clk) remap <= 16'h1248;
        acs(3'b100, 1, 4'hA); // Reversed remap of nibble 5
        @(posedge clk) ddr2 <= 0;
        acs(3'b100, 0, 4'h0); // Termination off outside DDR2 mode
        @(posedge clk) {ddr2, acc} <= 5'h10;
        @(posedge clk) #1 chk(ch0, 4'h0);
        @(posedge clk) rstn <= 0;
        @(posedge clk) rstn <= 1;
        cfg(1, 8'hB0, '0);
        chk(rdata, '0);
        chk(seen1, 4'h0);
        print_verdict;
    end
    initial
    begin
        repeat (500) @(posedge clk);
        err_total++;
        print_verdict;
    end
endmodule // tb_top
